// File: hw/hio_pkg.sv
/*
 package for the host i/o sleep and general output register block:
 port addresses, bit positions, reset values, write masks, carrier types.
 assumes 16-bit i/o addresses and 8-bit i/o data.
*/
package hio_pkg;

   // i/o port addresses
   localparam logic [15:0] PORT_PLANAR_ACCESS   = 16'h0094;
   localparam logic [15:0] PORT_SUBSYS_ENABLE   = 16'h0102;
   localparam logic [15:0] PORT_GENOUT_WR       = 16'h03C2;
   localparam logic [15:0] PORT_GENOUT_RD       = 16'h03CC;
   localparam logic [15:0] PORT_PLANAR_SLEEP    = 16'h03C3;
   localparam logic [15:0] PORT_ADAPTER_SLEEP   = 16'h46E8;
   localparam logic [15:0] PORT_FEATURE_RD      = 16'h03CA;
   localparam logic [15:0] PORT_STATUS_COLOUR   = 16'h03DA;
   localparam logic [15:0] PORT_STATUS_MONO     = 16'h03BA;
   localparam logic [15:0] PORT_TINDEX_COLOUR   = 16'h03D4;
   localparam logic [15:0] PORT_TDATA_COLOUR    = 16'h03D5;
   localparam logic [15:0] PORT_TINDEX_MONO     = 16'h03B4;
   localparam logic [15:0] PORT_TDATA_MONO      = 16'h03B5;

   // bit positions
   localparam int PAC_ACCESS_BIT  = 5;
   localparam int SE_ENABLE_BIT   = 0;
   localparam int PS_ENABLE_BIT   = 0;
   localparam int AS_SETUP_BIT    = 4;
   localparam int AS_ENABLE_BIT   = 3;
   localparam int GO_VPOL_BIT     = 7;
   localparam int GO_HPOL_BIT     = 6;
   localparam int GO_PAGE_BIT     = 5;
   localparam int GO_CLK_HI_BIT   = 3;
   localparam int GO_CLK_LO_BIT   = 2;
   localparam int GO_MEM_EN_BIT   = 1;
   localparam int GO_COLOUR_BIT   = 0;
   localparam int FC_VSYNC_BIT    = 3;

   // reset values
   localparam logic [7:0] PAC_RESET      = 8'h20;
   localparam logic [7:0] SE_RESET       = 8'h00;
   localparam logic [7:0] PS_RESET       = 8'h00;
   localparam logic [7:0] AS_RESET       = 8'h00;
   localparam logic [7:0] GO_RESET       = 8'h00;
   localparam logic [7:0] FC_RESET       = 8'h00;

   // implemented bits; all others read zero and ignore writes
   localparam logic [7:0] PAC_MASK       = 8'h20;
   localparam logic [7:0] SE_MASK        = 8'h01;
   localparam logic [7:0] PS_MASK        = 8'h01;
   localparam logic [7:0] AS_MASK        = 8'h18;
   localparam logic [7:0] GO_MASK        = 8'hEF;
   localparam logic [7:0] FC_MASK        = 8'h08;

   localparam logic [7:0] RDATA_IDLE     = 8'h00;
   localparam int         SYNC_STAGES    = 2;

   // one host i/o request, valid for one clock
   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [7:0]  wdata;
   } hio_io_req_t;

   // raw timing signals from the display timing unit
   typedef struct packed {
      logic hsync;
      logic vsync;
      logic display_enable;
   } hio_timing_t;

   // pixel clock routing
   typedef struct packed {
      logic [1:0] synth_select;
      logic       ext_to_converter;
      logic       ext_to_counters;
   } hio_pixclk_t;

endpackage

// File: hw/hio_sync2.sv
/*
 multi-bit two flip-flop synchroniser for static levels from pins.
 assumes each bit is an independent slow level.
*/
`timescale 1ns/1ps
`default_nettype none
module hio_sync2 #(
   parameter int WIDTH  = 1,
   parameter int STAGES = hio_pkg::SYNC_STAGES
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_r [STAGES];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < STAGES; i++) begin
            stage_r[i] <= '0;
         end
      end else begin
         stage_r[0] <= async_in;
         for (int i = 1; i < STAGES; i++) begin
            stage_r[i] <= stage_r[i-1];
         end
      end
   end

   assign sync_out = stage_r[STAGES-1];

endmodule
`default_nettype wire

// File: hw/hio_sync_out.sv
/*
 sync output stage: vertical sync display enable merge and polarity of both syncs.
 assumes raw syncs are active high and on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module hio_sync_out (
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire hio_pkg::hio_timing_t timing,
   input  wire logic                 hsync_invert,
   input  wire logic                 vsync_invert,
   input  wire logic                 vsync_merge_enable,
   output logic                      hsync_pin,
   output logic                      vsync_pin
);

   logic vsync_merged;

   assign vsync_merged = timing.vsync | (vsync_merge_enable & timing.display_enable); // RL22

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hsync_pin <= 1'b0;
         vsync_pin <= 1'b0;
      end else begin
         hsync_pin <= timing.hsync ^ hsync_invert;   // RL15
         vsync_pin <= vsync_merged ^ vsync_invert;   // RL14
      end
   end

endmodule
`default_nettype wire

// File: hw/hio_regs.sv
/*
 host i/o sleep, subsystem enable, general output and feature control registers.
 requests arrive one clock wide; claim answers in the same clock, ready and
 read data one clock later. strap pin is asynchronous and synchronised here.
*/
// Operation
// RL1: access bit resets one; zero opens subsystem enable
// RL2: latch access-control writes without claim or ready
// RL3: access control write only, reads return nothing
// RL4: access bit zero forces planar sleep
// RL5: subsystem enable decode depends on sleep configuration
// RL6: subsystem disabled answers only its own ports
// RL7: run needs subsystem and sleep enables set
// RL8: planar sleep always reachable; adapter config ignores it
// RL9: planar run needs three enable bits set
// RL10: planar asleep answers only its sleep ports
// RL11: setup bit opens ports, blocks display memory
// RL12: adapter asleep answers only its sleep ports
// RL13: general output written one port, read another
// RL14: bit seven sets vertical sync polarity
// RL15: bit six sets horizontal sync polarity
// RL16: page bit picks odd or even locations
// RL17: strap high selects one of four synthesizers
// RL18: strap low routes external clock pin
// RL19: memory enable bit zero ignores display memory
// RL20: colour bit moves status and timing ports
// RL21: feature control split ports, follows mono decode
// RL22: feature bit three merges display enable into vsync
// RL23: no sleep ports decoded on pci bus
// RL24: reserved bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none
module hio_regs (
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire hio_pkg::hio_io_req_t io_req,
   output logic                      io_claim,
   output logic                      io_ready,
   output logic [7:0]                io_rdata,
   input  wire logic                 cfg_pci_bus,
   input  wire logic                 cfg_adapter_sleep,
   input  wire logic                 external_clock_strap_n,
   input  wire logic                 seq_even_odd,
   input  wire logic                 seq_chain_four,
   input  wire logic                 graphics_chain,
   input  wire hio_pkg::hio_timing_t timing,
   output logic                      device_enabled,
   output logic                      setup_mode,
   output logic                      display_mem_enable,
   output logic                      bios_enable,
   output logic                      page_override,
   output logic                      page_low_bit,
   output hio_pkg::hio_pixclk_t      pixel_clock,
   output logic                      mono_decode,
   output logic                      timing_index_hit,
   output logic                      timing_data_hit,
   output logic                      status_hit,
   output logic                      hsync_pin,
   output logic                      vsync_pin
);

   function automatic logic port_is(input logic [15:0] a, input logic [15:0] p);
      port_is = (a == p);
   endfunction

   logic [7:0] planar_access_control_r;
   logic [7:0] subsystem_enable_r;
   logic [7:0] general_output_r;
   logic [7:0] planar_sleep_r;
   logic [7:0] feature_control_r;
   logic [7:0] adapter_sleep_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       ready_r;
   logic       strap_n_sync;
   logic       vl_bus;
   logic       planar_cfg;
   logic       access_bit;
   logic       subsys_bit;
   logic       planar_sleep_eff;
   logic       adapter_run_bit;
   logic       setup_bit;
   logic       run;
   logic       any_req;
   logic       hit_pac;
   logic       hit_se;
   logic       hit_ps;
   logic       hit_as;
   logic       hit_go_wr;
   logic       hit_go_rd;
   logic       hit_fc_wr;
   logic       hit_fc_rd;
   logic       fc_wr_port;
   logic       claim_hit;
   logic       read_hit;

   hio_sync2 #(
      .WIDTH  (1),
      .STAGES (hio_pkg::SYNC_STAGES)
   ) u_strap_sync (
      .clock    (clock),
      .rst      (rst),
      .async_in (external_clock_strap_n),
      .sync_out (strap_n_sync)
   );

   // configuration and enable state
   assign vl_bus          = ~cfg_pci_bus;
   assign planar_cfg      = ~cfg_adapter_sleep;
   assign access_bit      = planar_access_control_r[hio_pkg::PAC_ACCESS_BIT];
   assign subsys_bit      = subsystem_enable_r[hio_pkg::SE_ENABLE_BIT];
   assign planar_sleep_eff = planar_sleep_r[hio_pkg::PS_ENABLE_BIT] & access_bit; // RL4
   assign adapter_run_bit = adapter_sleep_r[hio_pkg::AS_ENABLE_BIT];
   assign setup_bit       = adapter_sleep_r[hio_pkg::AS_SETUP_BIT] & cfg_adapter_sleep & vl_bus;

   // pci config has no sleep registers and always runs
   always_comb begin
      if (cfg_pci_bus) begin
         run = 1'b1; // RL23
      end else if (planar_cfg) begin
         run = subsys_bit & planar_sleep_eff; // RL9
      end else begin
         run = subsys_bit & adapter_run_bit; // RL7
      end
   end

   assign device_enabled = run; // RL6
   assign setup_mode     = setup_bit;

   // sleep and subsystem port decode
   assign any_req = io_req.wr | io_req.rd;
   assign hit_pac = vl_bus & planar_cfg
                  & port_is(io_req.addr, hio_pkg::PORT_PLANAR_ACCESS); // RL23
   assign hit_ps  = vl_bus & planar_cfg
                  & port_is(io_req.addr, hio_pkg::PORT_PLANAR_SLEEP); // RL8
   assign hit_as  = vl_bus & cfg_adapter_sleep
                  & port_is(io_req.addr, hio_pkg::PORT_ADAPTER_SLEEP); // RL12
   assign hit_se  = vl_bus & port_is(io_req.addr, hio_pkg::PORT_SUBSYS_ENABLE)
                  & (cfg_adapter_sleep ? adapter_sleep_r[hio_pkg::AS_SETUP_BIT]
                                       : ~access_bit); // RL5

   // general registers answer only while running
   assign hit_go_wr  = run & port_is(io_req.addr, hio_pkg::PORT_GENOUT_WR); // RL13
   assign hit_go_rd  = run & port_is(io_req.addr, hio_pkg::PORT_GENOUT_RD); // RL13
   assign fc_wr_port = mono_decode ? port_is(io_req.addr, hio_pkg::PORT_STATUS_MONO)
                                   : port_is(io_req.addr, hio_pkg::PORT_STATUS_COLOUR);
   assign hit_fc_wr  = run & fc_wr_port; // RL21
   assign hit_fc_rd  = run & port_is(io_req.addr, hio_pkg::PORT_FEATURE_RD); // RL21

   // planar access control is latched silently
   always_comb begin
      claim_hit = 1'b0;
      if (io_req.wr) begin
         claim_hit = hit_se | hit_ps | hit_as | hit_go_wr | hit_fc_wr; // RL2
      end else if (io_req.rd) begin
         claim_hit = hit_se | hit_ps | hit_as | hit_go_rd | hit_fc_rd; // RL3
      end
   end

   assign io_claim = any_req & claim_hit; // RL10

   // read data mux, reserved bits masked to zero
   always_comb begin
      rdata_nxt = hio_pkg::RDATA_IDLE;
      read_hit  = 1'b0;
      if (io_req.rd) begin
         if (hit_se) begin
            rdata_nxt = subsystem_enable_r & hio_pkg::SE_MASK; // RL24
            read_hit  = 1'b1;
         end else if (hit_ps) begin
            rdata_nxt = planar_sleep_r & hio_pkg::PS_MASK;
            read_hit  = 1'b1;
         end else if (hit_as) begin
            rdata_nxt = adapter_sleep_r & hio_pkg::AS_MASK;
            read_hit  = 1'b1;
         end else if (hit_go_rd) begin
            rdata_nxt = general_output_r & hio_pkg::GO_MASK;
            read_hit  = 1'b1;
         end else if (hit_fc_rd) begin
            rdata_nxt = feature_control_r & hio_pkg::FC_MASK;
            read_hit  = 1'b1;
         end
      end
   end

   // planar access control
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         planar_access_control_r <= hio_pkg::PAC_RESET; // RL1
      end else if (io_req.wr && hit_pac) begin
         planar_access_control_r <= io_req.wdata & hio_pkg::PAC_MASK; // RL2
      end
   end

   // subsystem enable
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         subsystem_enable_r <= hio_pkg::SE_RESET; // RL6
      end else if (io_req.wr && hit_se) begin
         subsystem_enable_r <= io_req.wdata & hio_pkg::SE_MASK; // RL5
      end
   end

   // planar sleep
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         planar_sleep_r <= hio_pkg::PS_RESET;
      end else if (io_req.wr && hit_ps) begin
         planar_sleep_r <= io_req.wdata & hio_pkg::PS_MASK; // RL8
      end
   end

   // adapter sleep
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         adapter_sleep_r <= hio_pkg::AS_RESET; // RL11
      end else if (io_req.wr && hit_as) begin
         adapter_sleep_r <= io_req.wdata & hio_pkg::AS_MASK; // RL12
      end
   end

   // general output
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         general_output_r <= hio_pkg::GO_RESET;
      end else if (io_req.wr && hit_go_wr) begin
         general_output_r <= io_req.wdata & hio_pkg::GO_MASK; // RL24
      end
   end

   // feature control
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         feature_control_r <= hio_pkg::FC_RESET; // RL22
      end else if (io_req.wr && hit_fc_wr) begin
         feature_control_r <= io_req.wdata & hio_pkg::FC_MASK; // RL24
      end
   end

   // answer one clock after a claimed request
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ready_r <= 1'b0;
      end else begin
         ready_r <= any_req & claim_hit;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata_r <= hio_pkg::RDATA_IDLE;
      end else if (read_hit) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= hio_pkg::RDATA_IDLE; // RL3
      end
   end

   assign io_ready = ready_r;
   assign io_rdata = rdata_r;

   // memory decode enables
   assign display_mem_enable = run & ~setup_bit
                             & general_output_r[hio_pkg::GO_MEM_EN_BIT]; // RL19
   assign bios_enable        = 1'b1; // RL11

   // page select for even/odd addressing
   assign page_override = seq_even_odd & ~seq_chain_four & ~graphics_chain; // RL16
   assign page_low_bit  = ~general_output_r[hio_pkg::GO_PAGE_BIT]; // RL16

   // pixel clock routing
   always_comb begin
      pixel_clock.synth_select = general_output_r[hio_pkg::GO_CLK_HI_BIT:hio_pkg::GO_CLK_LO_BIT];
      if (strap_n_sync) begin
         pixel_clock.ext_to_converter = 1'b0; // RL17
         pixel_clock.ext_to_counters  = 1'b0;
      end else begin
         pixel_clock.ext_to_converter = 1'b1; // RL18
         pixel_clock.ext_to_counters  = general_output_r[hio_pkg::GO_CLK_HI_BIT];
      end
   end

   // monochrome or colour port placement
   assign mono_decode = ~general_output_r[hio_pkg::GO_COLOUR_BIT]; // RL20

   always_comb begin
      if (mono_decode) begin
         timing_index_hit = run & any_req
                          & port_is(io_req.addr, hio_pkg::PORT_TINDEX_MONO); // RL20
         timing_data_hit  = run & any_req
                          & port_is(io_req.addr, hio_pkg::PORT_TDATA_MONO);
         status_hit       = run & io_req.rd
                          & port_is(io_req.addr, hio_pkg::PORT_STATUS_MONO);
      end else begin
         timing_index_hit = run & any_req
                          & port_is(io_req.addr, hio_pkg::PORT_TINDEX_COLOUR); // RL20
         timing_data_hit  = run & any_req
                          & port_is(io_req.addr, hio_pkg::PORT_TDATA_COLOUR);
         status_hit       = run & io_req.rd
                          & port_is(io_req.addr, hio_pkg::PORT_STATUS_COLOUR);
      end
   end

   hio_sync_out u_sync_out (
      .clock              (clock),
      .rst                (rst),
      .timing             (timing),
      .hsync_invert       (general_output_r[hio_pkg::GO_HPOL_BIT]), // RL15
      .vsync_invert       (general_output_r[hio_pkg::GO_VPOL_BIT]), // RL14
      .vsync_merge_enable (feature_control_r[hio_pkg::FC_VSYNC_BIT]), // RL22
      .hsync_pin          (hsync_pin),
      .vsync_pin          (vsync_pin)
   );

endmodule
`default_nettype wire

// File: dv/hio_regs_monitor.sv
/*
 port checker for the host i/o register block.
 assumes it is bound onto hio_regs, one clock, async active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module hio_regs_monitor (
   input wire logic                 clock,
   input wire logic                 rst,
   input wire hio_pkg::hio_io_req_t io_req,
   input wire logic                 io_claim,
   input wire logic                 io_ready,
   input wire logic [7:0]           io_rdata,
   input wire logic                 cfg_pci_bus,
   input wire hio_pkg::hio_timing_t timing,
   input wire logic                 device_enabled,
   input wire logic                 setup_mode,
   input wire logic                 display_mem_enable,
   input wire logic                 mono_decode,
   input wire logic                 timing_index_hit,
   input wire logic                 hsync_pin,
   input wire logic                 vsync_pin
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_claimed;
      (io_req.wr || io_req.rd) && io_claim;
   endsequence
   sequence s_sleep_port;
      io_req.addr == hio_pkg::PORT_PLANAR_ACCESS || io_req.addr == hio_pkg::PORT_SUBSYS_ENABLE
      || io_req.addr == hio_pkg::PORT_PLANAR_SLEEP || io_req.addr == hio_pkg::PORT_ADAPTER_SLEEP;
   endsequence
   a_ready_after_claim: assert property (s_claimed |=> io_ready)
      else $error("no ready after claimed request");
   a_no_stray_ready: assert property (!io_claim |=> !io_ready)
      else $error("ready without claim");
   a_rdata_idle: assert property (!io_ready |-> io_rdata == 8'h00)
      else $error("read data not idle");
   a_access_unclaimed: assert property (io_req.addr == hio_pkg::PORT_PLANAR_ACCESS |-> !io_claim)
      else $error("access control port claimed");
   a_pci_sleep_shut: assert property (cfg_pci_bus ##0 s_sleep_port |-> !io_claim)
      else $error("sleep port claimed on pci");
   a_setup_blocks_mem: assert property (setup_mode |-> !display_mem_enable)
      else $error("display memory served in setup");
   a_asleep_no_mem: assert property (!device_enabled |-> !display_mem_enable)
      else $error("display memory served asleep");
   a_hsync_follows: assert property (!$past(rst) && $changed(timing.hsync) && !$past(io_req.wr)
      |=> $changed(hsync_pin))
      else $error("hsync pin missed raw edge");
   a_vsync_follows: assert property (!$past(rst) && $changed(timing.vsync) && !$past(io_req.wr)
      && !timing.display_enable && !$past(timing.display_enable) |=> $changed(vsync_pin))
      else $error("vsync pin missed raw edge");
   a_index_follows: assert property (timing_index_hit |-> io_req.addr == (mono_decode ?
      hio_pkg::PORT_TINDEX_MONO : hio_pkg::PORT_TINDEX_COLOUR))
      else $error("timing index hit at wrong port");
endmodule
`default_nettype wire

// File: dv/hio_host.sv
/*
 host processor model issuing one i/o cycle at a time.
 assumes inputs change a small delay after the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module hio_host (
   input  wire logic                 clock,
   input  wire logic                 io_claim,
   input  wire logic                 io_ready,
   input  wire logic [7:0]           io_rdata,
   output var hio_pkg::hio_io_req_t  io_req
);
   initial io_req = '0;
   // one request cycle, then the bus released with inverted lines
   task automatic cycle(input logic [15:0] a, input logic w, input logic [7:0] d,
                        output logic cl, output logic rdy, output logic [7:0] q);
      @(posedge clock);
      #1 io_req = '{addr: a, wr: w, rd: !w, wdata: d};
      @(negedge clock);
      cl = io_claim;
      @(posedge clock);
      #1 io_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
      @(negedge clock);
      rdy = io_ready;
      q = io_rdata;
   endtask
endmodule
`default_nettype wire

// File: dv/host_io_sleep_and_output_ctrl_test.sv
/*
 self-checking bench for hio_regs through the host model.
 assumes hio_pkg, hio_regs, hio_host and the monitor are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module host_io_sleep_and_output_ctrl_test;
   logic                 clock, rst, cfg_pci_bus, cfg_adapter_sleep, strap_n;
   logic                 even_odd, chain_four, chain, cl, rdy;
   logic [7:0]           q;
   hio_pkg::hio_io_req_t io_req;
   hio_pkg::hio_timing_t timing;
   hio_pkg::hio_pixclk_t pixel_clock;
   logic                 io_claim, io_ready, device_enabled, setup_mode, display_mem_enable;
   logic                 bios_enable, page_override, page_low_bit, mono_decode, hsync_pin;
   logic                 vsync_pin;
   logic [7:0]           io_rdata;
   logic [2:0]           hits, hits_seen;
   int                   n_fail, checks_done;
   logic [15:0]          sp [4] = '{16'h0094, 16'h0102, 16'h03C3, 16'h46E8};

   hio_host host_u (.clock(clock), .io_claim(io_claim), .io_ready(io_ready),
      .io_rdata(io_rdata), .io_req(io_req));
   hio_regs dut_u (.clock(clock), .rst(rst), .io_req(io_req), .io_claim(io_claim),
      .io_ready(io_ready), .io_rdata(io_rdata), .cfg_pci_bus(cfg_pci_bus),
      .cfg_adapter_sleep(cfg_adapter_sleep), .external_clock_strap_n(strap_n),
      .seq_even_odd(even_odd), .seq_chain_four(chain_four), .graphics_chain(chain),
      .timing(timing), .device_enabled(device_enabled), .setup_mode(setup_mode),
      .display_mem_enable(display_mem_enable), .bios_enable(bios_enable),
      .page_override(page_override), .page_low_bit(page_low_bit), .pixel_clock(pixel_clock),
      .mono_decode(mono_decode), .timing_index_hit(hits[2]), .timing_data_hit(hits[1]),
      .status_hit(hits[0]),
      .hsync_pin(hsync_pin), .vsync_pin(vsync_pin));

   initial clock = 1'b0;
   always #20 clock = ~clock;
   // remember which timing/status decode pulsed during a request
   always @(negedge clock) if (|hits) hits_seen = hits;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chb(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic ecl);
      host_u.cycle(a, 1'b1, d, cl, rdy, q);
      chb(cl, ecl);
      chb(rdy, ecl);
   endtask
   task automatic rd(input logic [15:0] a, input logic ecl, input logic [7:0] ed);
      host_u.cycle(a, 1'b0, 8'h00, cl, rdy, q);
      chb(cl, ecl);
      chk(q, ed);
   endtask
   task automatic thit(input logic [15:0] a, input logic [2:0] exp);
      hits_seen = 3'h0;
      rd(a, 1'b0, 8'h00);
      chk({5'h00, hits_seen}, {5'h00, exp});
   endtask
   // raw timing change, then look at the pins once registered
   task automatic sync_to(input logic h, input logic v, input logic de);
      @(posedge clock);
      #1 timing = '{hsync: h, vsync: v, display_enable: de};
      repeat (2) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      #(40 * 4000);
      n_fail++;
      tally_and_finish();
   end

   initial begin
      rst = 1'b1; cfg_pci_bus = 1'b0; cfg_adapter_sleep = 1'b0; strap_n = 1'b1;
      even_odd = 1'b0; chain_four = 1'b0; chain = 1'b0; timing = '0;
      repeat (20) @(posedge clock);
      #1 rst = 1'b0;
      // planar configuration out of reset
      rd(16'h03CC, 1'b0, 8'h00);
      rd(16'h0102, 1'b0, 8'h00);
      rd(16'h03C3, 1'b1, 8'h00);
      rd(16'h0094, 1'b0, 8'h00);
      wr(16'h0094, 8'h00, 1'b0);
      rd(16'h0102, 1'b1, 8'h00);
      wr(16'h0102, 8'hFF, 1'b1);
      rd(16'h0102, 1'b1, 8'h01);
      wr(16'h03C3, 8'hFF, 1'b1);
      rd(16'h03C3, 1'b1, 8'h01);
      chb(device_enabled, 1'b0);
      wr(16'h0094, 8'hFF, 1'b0);
      chb(device_enabled, 1'b1);
      rd(16'h0102, 1'b0, 8'h00);
      wr(16'h03C2, 8'hFF, 1'b1);
      rd(16'h03CC, 1'b1, 8'hEF);
      chb(mono_decode, 1'b0);
      wr(16'h03DA, 8'hFF, 1'b1);
      rd(16'h03CA, 1'b1, 8'h08);
      wr(16'h03BA, 8'h00, 1'b0);
      for (int p = 0; p < 4; p++) begin
         wr(16'h03C2, {p[1:0], 6'h03}, 1'b1);
         sync_to(1'b1, 1'b1, 1'b0);
         chb(hsync_pin, ~p[0]);
         chb(vsync_pin, ~p[1]);
         sync_to(1'b0, 1'b0, 1'b1);
         chb(hsync_pin, p[0]);
         chb(vsync_pin, ~p[1]);
         sync_to(1'b0, 1'b0, 1'b0);
         chb(vsync_pin, p[1]);
      end
      wr(16'h03DA, 8'h00, 1'b1);
      sync_to(1'b0, 1'b0, 1'b1);
      chb(vsync_pin, 1'b1);
      for (int c = 0; c < 4; c++) begin
         wr(16'h03C2, {4'h0, c[1:0], 2'b01}, 1'b1);
         chk({6'h00, pixel_clock.synth_select}, {6'h00, c[1:0]});
         chb(display_mem_enable, 1'b0);
      end
      @(posedge clock);
      #1 strap_n = 1'b0;
      repeat (3) @(posedge clock);
      wr(16'h03C2, 8'h0B, 1'b1);
      chb(pixel_clock.ext_to_counters, 1'b1);
      chb(pixel_clock.ext_to_converter, 1'b1);
      chb(display_mem_enable, 1'b1);
      wr(16'h03C2, 8'h23, 1'b1);
      chb(pixel_clock.ext_to_counters, 1'b0);
      @(posedge clock);
      #1 even_odd = 1'b1;
      @(negedge clock);
      chb(page_override, 1'b1);
      chb(page_low_bit, 1'b0);
      @(posedge clock);
      #1 chain_four = 1'b1;
      @(negedge clock);
      chb(page_override, 1'b0);
      wr(16'h03C2, 8'h02, 1'b1);
      chb(mono_decode, 1'b1);
      wr(16'h03BA, 8'hFF, 1'b1);
      rd(16'h03CA, 1'b1, 8'h08);
      wr(16'h03DA, 8'h00, 1'b0);
      thit(16'h03B4, 3'h4);
      thit(16'h03B5, 3'h2);
      thit(16'h03BA, 3'h1);
      thit(16'h03D4, 3'h0);
      wr(16'h03C3, 8'h00, 1'b1);
      chb(device_enabled, 1'b0);
      chb(display_mem_enable, 1'b0);
      chb(bios_enable, 1'b1);
      rd(16'h03CC, 1'b0, 8'h00);
      rd(16'h03C3, 1'b1, 8'h00);
      // adapter configuration after a second reset
      @(posedge clock);
      #1 rst = 1'b1;
      cfg_adapter_sleep = 1'b1;
      repeat (2) @(posedge clock);
      #1 rst = 1'b0;
      rd(16'h03C3, 1'b0, 8'h00);
      rd(16'h0102, 1'b0, 8'h00);
      wr(16'h46E8, 8'hFF, 1'b1);
      rd(16'h46E8, 1'b1, 8'h18);
      chb(setup_mode, 1'b1);
      chb(display_mem_enable, 1'b0);
      wr(16'h0102, 8'h01, 1'b1);
      chb(device_enabled, 1'b1);
      wr(16'h46E8, 8'h08, 1'b1);
      chb(setup_mode, 1'b0);
      rd(16'h0102, 1'b0, 8'h00);
      wr(16'h46E8, 8'h00, 1'b1);
      chb(device_enabled, 1'b0);
      rd(16'h46E8, 1'b1, 8'h00);
      rd(16'h03CC, 1'b0, 8'h00);
      @(posedge clock);
      #1 cfg_pci_bus = 1'b1;
      foreach (sp[i])
         rd(sp[i], 1'b0, 8'h00);
      rd(16'h03CC, 1'b1, 8'h00);
      tally_and_finish();
   end
endmodule
bind hio_regs hio_regs_monitor mon_u (.clock(clock), .rst(rst), .io_req(io_req),
   .io_claim(io_claim), .io_ready(io_ready), .io_rdata(io_rdata), .cfg_pci_bus(cfg_pci_bus),
   .timing(timing), .device_enabled(device_enabled), .setup_mode(setup_mode),
   .display_mem_enable(display_mem_enable), .mono_decode(mono_decode),
   .timing_index_hit(timing_index_hit), .hsync_pin(hsync_pin), .vsync_pin(vsync_pin));
`default_nettype wire
